// ---- inc/display_pmic_map.vh ----
// address map, field positions, reset values and timing counts of the rail control bank
`ifndef DISPLAY_PMIC_MAP_VH
`define DISPLAY_PMIC_MAP_VH

// register addresses (one byte each, consecutive)
`define ADDR_TEMP_READING      8'h00
`define ADDR_RAIL_ENABLE       8'h01
`define ADDR_SOURCE_VSEL       8'h02
`define ADDR_BIAS_LOW          8'h03
`define ADDR_BIAS_HIGH         8'h04
`define ADDR_IRQ_MASK_A        8'h05
`define ADDR_IRQ_MASK_B        8'h06
`define ADDR_IRQ_FLAGS_A       8'h07
`define ADDR_IRQ_FLAGS_B       8'h08
`define ADDR_UPSEQ_STROBE      8'h09
`define ADDR_UPSEQ_DELAY       8'h0a
`define ADDR_DNSEQ_STROBE      8'h0b
`define ADDR_DNSEQ_DELAY       8'h0c
`define ADDR_THERM_CONFIG      8'h0d
`define ADDR_THERM_HOT         8'h0e
`define ADDR_RAIL_GOOD         8'h0f
`define ADDR_REVISION          8'h10

// rail enable register fields
`define EN_GO_ACTIVE           7
`define EN_GO_STANDBY          6
`define EN_PANEL_SWITCH        5
`define EN_BIAS_BUFFER         4
`define EN_POS_GATE_PUMP       3
`define EN_POS_SOURCE_REG      2
`define EN_NEG_GATE_PUMP       1
`define EN_NEG_SOURCE_REG      0

// reset values
`define RST_RAIL_ENABLE        8'h00
`define RST_SOURCE_VSEL        8'h23
`define RST_PLAIN_BYTE         8'h00
`define VSEL_RO_BIT            3

// temperature saturation limits (two's complement degrees)
`define TEMP_SAT_LOW           8'hf6
`define TEMP_SAT_HIGH          8'h55

// target address of the serial port (arbitrary value)
`define TARGET_ADDR            7'h48
// revision code (arbitrary value)
`define REVISION_CODE          8'h5a

// timing: clock period and time a mode transition takes
`define CLK_PERIOD_NS          50
`define SEQ_TIME_NS            1000
// transition length in clocks at the nominal clock, sized for the timer
`define SEQ_CYCLES_DEF         16'd20

`endif

// ---- verilog/display_pmic_rail_control_regs.v ----
// byte register bank with serial target port and rail mode control
//
// How it works
// - seventeen byte registers at addresses 00h to 10h
// - temperature is read-only, saturating two's complement
// - rail enable register resets to zero
// - writing go-active in standby starts power-up
// - go-active bit clears itself after transition
// - go-standby clears itself, and beats go-active
// - go-standby while awake powers rails down
// - bit five switches the panel supply
// - bits four, three, one enable pumps/buffer
// - positive source needs negative source enabled
// - negative source off forces positive off
// - voltage register resets 23h, bit three zero
// - three-bit voltage code resets to 3h
// - serial port, address auto-increments per byte
// - wake low holds defaults, ignores serial traffic
`include "display_pmic_map.vh"

module display_pmic_rail_control_regs #(
  parameter [15:0] SEQ_CYCLES = `SEQ_CYCLES_DEF  // length of one mode transition
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset,
  // wake pin
  input  wire       wake_input,
  // serial port pins (data is open drain)
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // inputs from the analogue side, same clock
  input  wire [7:0] temperature_raw,
  input  wire [7:0] irq_flags_a,
  input  wire [7:0] irq_flags_b,
  input  wire [7:0] rail_good,
  // rail controls
  output reg        panel_switch_on,
  output reg        bias_buffer_on,
  output reg        pos_gate_pump_on,
  output reg        pos_source_reg_on,
  output reg        neg_gate_pump_on,
  output reg        neg_source_reg_on,
  output reg  [2:0] source_voltage_code,
  output reg        device_active
);

  // serial port states, one-hot
  localparam [6:0] S_IDLE = 7'h01;  // waiting for a start
  localparam [6:0] S_DEV  = 7'h02;  // receiving target address
  localparam [6:0] S_ACK  = 7'h04;  // driving acknowledge
  localparam [6:0] S_SUB  = 7'h08;  // receiving register address
  localparam [6:0] S_WR   = 7'h10;  // receiving write data
  localparam [6:0] S_RD   = 7'h20;  // sending read data
  localparam [6:0] S_RACK = 7'h40;  // sampling controller acknowledge

  // mode states, one-hot
  localparam [3:0] M_STANDBY = 4'h1;  // rails off, ready
  localparam [3:0] M_UP      = 4'h2;  // rails powering up
  localparam [3:0] M_ACTIVE  = 4'h4;  // rails live
  localparam [3:0] M_DOWN    = 4'h8;  // rails powering down

  // synchronisers: first stage is read only by the second
  reg        scl_meta_reg;   // scl first stage
  reg        scl_sync_reg;   // scl second stage
  reg        scl_last_reg;   // scl previous value, for edges
  reg        sda_meta_reg;   // sda first stage
  reg        sda_sync_reg;   // sda second stage
  reg        sda_last_reg;   // sda previous value
  reg        wake_meta_reg;  // wake first stage
  reg        wake_sync_reg;  // wake second stage

  // serial port state
  reg  [6:0] port_state_reg;  // current port state
  reg  [6:0] ack_to_reg;      // state entered after acknowledge
  reg  [3:0] bit_cnt_reg;     // bits moved in current byte
  reg  [7:0] rx_shift_reg;    // incoming byte
  reg  [7:0] tx_shift_reg;    // outgoing byte, msb on the wire
  reg  [7:0] reg_addr_reg;    // register pointer
  reg        ctrl_ack_reg;    // controller acknowledged last read byte
  reg        wr_stb_reg;      // one-cycle write strobe
  reg  [7:0] wr_addr_reg;     // write address
  reg  [7:0] wr_data_reg;     // write data

  // register contents
  reg  [7:0] rail_enable_reg;   // rail enable control
  reg  [7:0] source_vsel_reg;   // source voltage select
  reg  [7:0] plain_mem [0:16];  // plain read/write bytes, indexed by address
  reg  [3:0] mode_reg;          // power mode
  reg [15:0] seq_timer_reg;     // transition countdown

  // mode next values
  reg  [3:0] mode_next;
  reg [15:0] seq_timer_next;
  reg        act_clr;   // go-active request served
  reg        stby_clr;  // go-standby request served

  integer i;

  // edge and condition decode from the synchronised pins
  wire scl_rise = scl_sync_reg & ~scl_last_reg;
  wire scl_fall = ~scl_sync_reg & scl_last_reg;
  wire bus_start = scl_sync_reg & scl_last_reg & sda_last_reg & ~sda_sync_reg;
  wire bus_stop  = scl_sync_reg & scl_last_reg & ~sda_last_reg & sda_sync_reg;

  // write decode of the request bits
  wire en_write   = wr_stb_reg & (wr_addr_reg == `ADDR_RAIL_ENABLE);
  wire act_set    = en_write & wr_data_reg[`EN_GO_ACTIVE];   // only a 1 acts
  wire stby_set   = en_write & wr_data_reg[`EN_GO_STANDBY];
  wire act_pend   = rail_enable_reg[`EN_GO_ACTIVE];
  wire stby_pend  = rail_enable_reg[`EN_GO_STANDBY];

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  // acknowledge, or a zero data bit, pulls the line
  assign sda_oe = (port_state_reg == S_ACK) |
                  ((port_state_reg == S_RD) & ~tx_shift_reg[7]);

  // true for bytes held as plain storage with no side effects
  function is_plain;
    input [7:0] a;
    begin
      is_plain = ((a >= `ADDR_BIAS_LOW) && (a <= `ADDR_IRQ_MASK_B)) ||
                 ((a >= `ADDR_UPSEQ_STROBE) && (a <= `ADDR_THERM_HOT));
    end
  endfunction

  // clamp the raw reading into the reported range
  function [7:0] clamp_temp;
    input [7:0] t;
    begin
      if ($signed(t) < $signed(`TEMP_SAT_LOW)) begin
        clamp_temp = `TEMP_SAT_LOW;
      end else if ($signed(t) > $signed(`TEMP_SAT_HIGH)) begin
        clamp_temp = `TEMP_SAT_HIGH;
      end else begin
        clamp_temp = t;
      end
    end
  endfunction

  // read data for an address; unmapped addresses read zero
  function [7:0] read_byte;
    input [7:0] a;
    begin
      if (is_plain(a)) begin
        read_byte = plain_mem[a[4:0]];
      end else begin
        case (a)
          `ADDR_TEMP_READING: read_byte = clamp_temp(temperature_raw);
          `ADDR_RAIL_ENABLE:  read_byte = rail_enable_reg;
          `ADDR_SOURCE_VSEL:  read_byte = source_vsel_reg;  // bit 3 held zero
          `ADDR_IRQ_FLAGS_A:  read_byte = irq_flags_a;
          `ADDR_IRQ_FLAGS_B:  read_byte = irq_flags_b;
          `ADDR_RAIL_GOOD:    read_byte = rail_good;
          `ADDR_REVISION:     read_byte = `REVISION_CODE;
          default:            read_byte = 8'h00;
        endcase
      end
    end
  endfunction

  // pin synchronisers, two flops each
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_meta_reg  <= 1'b1;
      scl_sync_reg  <= 1'b1;
      scl_last_reg  <= 1'b1;
      sda_meta_reg  <= 1'b1;
      sda_sync_reg  <= 1'b1;
      sda_last_reg  <= 1'b1;
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      scl_meta_reg  <= scl_in;
      scl_sync_reg  <= scl_meta_reg;
      scl_last_reg  <= scl_sync_reg;
      sda_meta_reg  <= sda_in;
      sda_sync_reg  <= sda_meta_reg;
      sda_last_reg  <= sda_sync_reg;
      wake_meta_reg <= wake_input;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // serial target: address, pointer, write strobes, read shifting
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_state_reg <= S_IDLE;
      ack_to_reg     <= S_IDLE;
      bit_cnt_reg    <= 4'h0;
      rx_shift_reg   <= 8'h00;
      tx_shift_reg   <= 8'hff;
      reg_addr_reg   <= 8'h00;
      ctrl_ack_reg   <= 1'b0;
      wr_stb_reg     <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 8'h00;
    end else if (!wake_sync_reg) begin
      // asleep: the port neither answers nor remembers
      port_state_reg <= S_IDLE;
      ack_to_reg     <= S_IDLE;
      bit_cnt_reg    <= 4'h0;
      rx_shift_reg   <= 8'h00;
      tx_shift_reg   <= 8'hff;
      reg_addr_reg   <= 8'h00;
      ctrl_ack_reg   <= 1'b0;
      wr_stb_reg     <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (bus_start) begin
        // start or repeated start always restarts address reception
        port_state_reg <= S_DEV;
        bit_cnt_reg    <= 4'h0;
      end else if (bus_stop) begin
        port_state_reg <= S_IDLE;
      end else begin
        case (port_state_reg)
          S_DEV, S_SUB, S_WR: begin
            if (scl_rise && (bit_cnt_reg != 4'h8)) begin
              // data is sampled on the rising clock edge
              rx_shift_reg <= {rx_shift_reg[6:0], sda_sync_reg};
              bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && (bit_cnt_reg == 4'h8)) begin
              bit_cnt_reg <= 4'h0;
              if (port_state_reg == S_DEV) begin
                if (rx_shift_reg[7:1] == `TARGET_ADDR) begin
                  port_state_reg <= S_ACK;
                  ack_to_reg     <= rx_shift_reg[0] ? S_RD : S_SUB;
                  tx_shift_reg   <= read_byte(reg_addr_reg);
                end else begin
                  // another target: stay off the line until next start
                  port_state_reg <= S_IDLE;
                end
              end else if (port_state_reg == S_SUB) begin
                reg_addr_reg   <= rx_shift_reg;
                port_state_reg <= S_ACK;
                ack_to_reg     <= S_WR;
              end else begin
                // every data byte is acknowledged, even when unmapped
                wr_stb_reg     <= 1'b1;
                wr_addr_reg    <= reg_addr_reg;
                wr_data_reg    <= rx_shift_reg;
                reg_addr_reg   <= reg_addr_reg + 8'h01;
                port_state_reg <= S_ACK;
                ack_to_reg     <= S_WR;
              end
            end
          end
          S_ACK: begin
            // release acknowledge on the falling edge that ends it
            if (scl_fall) begin
              port_state_reg <= ack_to_reg;
              bit_cnt_reg    <= 4'h0;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                port_state_reg <= S_RACK;
                bit_cnt_reg    <= 4'h0;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                bit_cnt_reg  <= bit_cnt_reg + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              ctrl_ack_reg <= ~sda_sync_reg;
            end else if (scl_fall) begin
              if (ctrl_ack_reg) begin
                // next byte from the following address
                reg_addr_reg   <= reg_addr_reg + 8'h01;
                tx_shift_reg   <= read_byte(reg_addr_reg + 8'h01);
                port_state_reg <= S_RD;
              end else begin
                port_state_reg <= S_IDLE;
              end
            end
          end
          S_IDLE: begin
            bit_cnt_reg <= 4'h0;
          end
          default: begin
            port_state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // mode sequencing; standby requests are looked at first
  always @* begin
    mode_next      = mode_reg;
    seq_timer_next = seq_timer_reg;
    act_clr        = 1'b0;
    stby_clr       = 1'b0;
    case (mode_reg)
      M_STANDBY: begin
        if (stby_pend) begin
          // already down: both requests retire, standby wins
          stby_clr = 1'b1;
          act_clr  = 1'b1;
        end else if (act_pend) begin
          mode_next      = M_UP;
          seq_timer_next = SEQ_CYCLES;
        end
      end
      M_UP: begin
        if (stby_pend) begin
          mode_next      = M_DOWN;
          seq_timer_next = SEQ_CYCLES;
          act_clr        = 1'b1;
        end else if (seq_timer_reg == 16'h0000) begin
          mode_next = M_ACTIVE;
          act_clr   = 1'b1;
        end else begin
          seq_timer_next = seq_timer_reg - 16'h0001;
        end
      end
      M_ACTIVE: begin
        if (stby_pend) begin
          mode_next      = M_DOWN;
          seq_timer_next = SEQ_CYCLES;
          act_clr        = 1'b1;
        end else if (act_pend) begin
          act_clr = 1'b1;  // nothing to do
        end
      end
      M_DOWN: begin
        if (seq_timer_reg == 16'h0000) begin
          mode_next = M_STANDBY;
          stby_clr  = 1'b1;
        end else begin
          seq_timer_next = seq_timer_reg - 16'h0001;
        end
      end
      default: begin
        mode_next = M_STANDBY;
      end
    endcase
  end

  // register storage, mode and transition timer
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rail_enable_reg <= `RST_RAIL_ENABLE;
      source_vsel_reg <= `RST_SOURCE_VSEL;
      mode_reg        <= M_STANDBY;
      seq_timer_reg   <= 16'h0000;
      for (i = 0; i < 17; i = i + 1) begin
        plain_mem[i] <= `RST_PLAIN_BYTE;
      end
    end else if (!wake_sync_reg) begin
      // sleep returns everything to defaults
      rail_enable_reg <= `RST_RAIL_ENABLE;
      source_vsel_reg <= `RST_SOURCE_VSEL;
      mode_reg        <= M_STANDBY;
      seq_timer_reg   <= 16'h0000;
      for (i = 0; i < 17; i = i + 1) begin
        plain_mem[i] <= `RST_PLAIN_BYTE;
      end
    end else begin
      mode_reg      <= mode_next;
      seq_timer_reg <= seq_timer_next;
      // a request written in the cycle it is served is kept
      rail_enable_reg[`EN_GO_ACTIVE]  <= act_set | (act_pend & ~act_clr);
      rail_enable_reg[`EN_GO_STANDBY] <= stby_set | (stby_pend & ~stby_clr);
      if (en_write) begin
        rail_enable_reg[5:0] <= wr_data_reg[5:0];
      end
      if (wr_stb_reg && (wr_addr_reg == `ADDR_SOURCE_VSEL)) begin
        // bit 3 stays zero, other bits written
        source_vsel_reg <= wr_data_reg & ~(8'h01 << `VSEL_RO_BIT);
      end
      if (wr_stb_reg && is_plain(wr_addr_reg)) begin
        plain_mem[wr_addr_reg[4:0]] <= wr_data_reg;
      end
      // writes to read-only addresses fall through untouched
    end
  end

  // rail drives follow the enables only while rails are live
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      panel_switch_on     <= 1'b0;
      bias_buffer_on      <= 1'b0;
      pos_gate_pump_on    <= 1'b0;
      pos_source_reg_on   <= 1'b0;
      neg_gate_pump_on    <= 1'b0;
      neg_source_reg_on   <= 1'b0;
      source_voltage_code <= 3'h3;
      device_active       <= 1'b0;
    end else begin
      device_active       <= (mode_reg == M_ACTIVE);
      panel_switch_on     <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_PANEL_SWITCH];
      bias_buffer_on      <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_BIAS_BUFFER];
      pos_gate_pump_on    <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_POS_GATE_PUMP];
      neg_gate_pump_on    <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_NEG_GATE_PUMP];
      neg_source_reg_on   <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_NEG_SOURCE_REG];
      // positive source only behind an enabled negative source
      pos_source_reg_on   <= (mode_reg == M_ACTIVE) & rail_enable_reg[`EN_POS_SOURCE_REG] &
                             rail_enable_reg[`EN_NEG_SOURCE_REG];
      // invalid codes pass through unchecked, the host must avoid them
      source_voltage_code <= source_vsel_reg[2:0];
    end
  end

endmodule // display_pmic_rail_control_regs

// ---- dv/i2c_host_model.sv ----
// serial host model: drives the clock line and pulls the data line of the target port
`include "display_pmic_map.vh"

module i2c_host_model #(
  parameter int HALF = 4  // clocks per quarter of one bit
) (
  // clock
  input  wire logic ref_clk,
  // bus lines
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: clock high, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // wait a number of clock edges
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one bit slot: data moves mid-low, sampled mid-high; b=1 releases the line
  task automatic bit_io(input logic b, output logic r);
    wt(HALF);
    sda_pull <= ~b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    r = sda_line;
    wt(HALF);
    scl <= 1'b0;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    wt(HALF);
    sda_pull <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_pull <= 1'b1;
    wt(HALF);
    scl <= 1'b0;
  endtask

  // stop: data rises while the clock is high, then the bus is idle
  task automatic stop();
    wt(HALF);
    sda_pull <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_pull <= 1'b0;
    wt(HALF);
  endtask

  // one byte out, most significant bit first, then the target's acknowledge slot
  task automatic send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask

  // write burst; the target steps its pointer after every data byte
  task automatic write_regs(input logic [7:0] a, input logic [7:0] d[$], output logic nak);
    logic n;
    start();
    send({`TARGET_ADDR, 1'b0}, nak);
    send(a, n);
    nak = nak | n;
    foreach (d[i]) begin
      send(d[i], n);
      nak = nak | n;
    end
    stop();
  endtask

  // read burst through a repeated start; last byte is not acknowledged
  task automatic read_regs(input logic [7:0] a, input int cnt, output logic [7:0] d[$]);
    logic       n;
    logic [7:0] b;
    start();
    send({`TARGET_ADDR, 1'b0}, n);
    send(a, n);
    start();
    send({`TARGET_ADDR, 1'b1}, n);
    d = {};
    for (int i = 0; i < cnt; i++) begin
      for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
      bit_io(i == cnt - 1, n);
      d.push_back(b);
    end
    stop();
  endtask
endmodule  // i2c_host_model

// ---- dv/display_pmic_rail_control_regs_checker.sv ----
// concurrent checks on the ports of the rail control bank
module display_pmic_rail_control_regs_checker #(
  parameter [15:0] SEQ_CYCLES = 16'd20  // length of one mode transition
) (
  // clock and reset
  input wire       ref_clk,
  input wire       reset,
  // pins
  input wire       wake_input,
  input wire       scl_in,
  input wire       sda_oe,
  // rail controls
  input wire       panel_switch_on,
  input wire       bias_buffer_on,
  input wire       pos_gate_pump_on,
  input wire       pos_source_reg_on,
  input wire       neg_gate_pump_on,
  input wire       neg_source_reg_on,
  input wire [2:0] source_voltage_code,
  input wire       device_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // any rail switched on
  wire any_rail = panel_switch_on | bias_buffer_on | pos_gate_pump_on | pos_source_reg_on
                | neg_gate_pump_on | neg_source_reg_on;

  a_pos_needs_neg: assert property (pos_source_reg_on |-> neg_source_reg_on)
    else $error("positive source on without negative source");
  a_neg_off_pos: assert property ($fell(neg_source_reg_on) |-> !pos_source_reg_on)
    else $error("positive source left on after negative source off");
  a_rails_need_active: assert property (any_rail |-> device_active)
    else $error("rail on outside active mode");
  a_up_takes_time: assert property ($rose(device_active) |-> !$past(device_active, SEQ_CYCLES))
    else $error("active mode reached too early");
  a_down_takes_time: assert property ($fell(device_active) && wake_input |->
    $past(device_active, SEQ_CYCLES)) else $error("standby reached too early");
  a_sleep_defaults: assert property (!wake_input [*6] |->
    !any_rail && !device_active && source_voltage_code == 3'h3) else $error("sleep not default");
  a_sleep_silent: assert property (!wake_input [*6] |-> !sda_oe)
    else $error("data line driven while asleep");
  a_sda_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_code_valid: assert property ($changed(source_voltage_code) |->
    source_voltage_code inside {[3'h3:3'h6]}) else $error("voltage code outside valid set");

  // main scenarios reached
  c_go_active: cover property ($rose(device_active));
  c_go_standby: cover property ($fell(device_active));
  c_target_drives: cover property (sda_oe && scl_in);
  c_interlock: cover property (neg_source_reg_on && !pos_source_reg_on);
endmodule  // display_pmic_rail_control_regs_checker

bind display_pmic_rail_control_regs display_pmic_rail_control_regs_checker #(
  .SEQ_CYCLES(SEQ_CYCLES)
) i_checker (
  .ref_clk(ref_clk), .reset(reset), .wake_input(wake_input), .scl_in(scl_in), .sda_oe(sda_oe),
  .panel_switch_on(panel_switch_on), .bias_buffer_on(bias_buffer_on),
  .pos_gate_pump_on(pos_gate_pump_on), .pos_source_reg_on(pos_source_reg_on),
  .neg_gate_pump_on(neg_gate_pump_on), .neg_source_reg_on(neg_source_reg_on),
  .source_voltage_code(source_voltage_code), .device_active(device_active)
);

// ---- dv/display_pmic_rail_control_regs_tb_top.sv ----
// register-level testbench of the rail control bank
`include "display_pmic_map.vh"

module display_pmic_rail_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEQ = 4;  // shortened transition so the run stays brief

  logic       ref_clk, reset, wake_input;             // clock, reset, wake pin
  logic [7:0] temperature_raw, irq_a, irq_b, rail_good; // analogue-side inputs
  logic       scl, sda_pull;                            // host side of the bus
  wire        sda_oe, sda_out, device_active;           // target side of the bus
  wire  [2:0] source_voltage_code;                      // selected voltage code
  wire  [5:0] rails;                                    // rail outputs in register bit order
  wire        sda_line = !(sda_pull || (sda_oe && !sda_out));  // pulled-up open drain
  logic [7:0] q[$];                                     // burst read result
  logic       nak;                                      // no acknowledge seen
  int         miscompares = 0;
  int         n_checks = 0;
  logic [7:0] t_in [7] = '{8'h80, 8'hf5, 8'hf6, 8'hff, 8'h55, 8'h56, 8'h7f};
  logic [7:0] t_ex [7] = '{8'hf6, 8'hf6, 8'hf6, 8'hff, 8'h55, 8'h55, 8'h55};

  display_pmic_rail_control_regs #(.SEQ_CYCLES(16'd4)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .wake_input(wake_input),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .temperature_raw(temperature_raw), .irq_flags_a(irq_a), .irq_flags_b(irq_b),
    .rail_good(rail_good), .panel_switch_on(rails[5]), .bias_buffer_on(rails[4]),
    .pos_gate_pump_on(rails[3]), .pos_source_reg_on(rails[2]), .neg_gate_pump_on(rails[1]),
    .neg_source_reg_on(rails[0]), .source_voltage_code(source_voltage_code),
    .device_active(device_active)
  );

  i2c_host_model #(.HALF(4)) i_host (.ref_clk(ref_clk), .scl(scl), .sda_pull(sda_pull),
    .sda_line(sda_line));

  // free-running clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // single-byte register access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_regs(a, {d}, nak);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_regs(a, 1, q);
    check(q[0], exp);
  endtask

  // bounded wait for the mode output, the transition takes only a few cycles
  task automatic wait_active(input logic v);
    int k;
    k = 0;
    while (device_active !== v && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    check(device_active, v);
  endtask

  // watchdog: the tests need about 22000 cycles
  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end

  // test sequence
  initial begin
    reset = 1'b1;
    wake_input = 1'b0;
    temperature_raw = 8'h19;
    irq_a = 8'h3c;
    irq_b = 8'hc3;
    rail_good = 8'ha5;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    wake_input <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(source_voltage_code, 8'h03);
    check({device_active, rails}, 8'h00);
    check(sda_out, 8'h00);
    i_host.read_regs(8'h00, 3, q);
    check(q[0], 8'h19);
    check(q[1], 8'h00);
    check(q[2], 8'h23);
    // temperature clamps at both ends
    foreach (t_in[i]) begin
      temperature_raw <= t_in[i];
      rd(8'h00, t_ex[i]);
    end
    // every valid voltage code; bit 3 written high must read back low
    for (int c = 3; c <= 6; c++) begin
      wr(8'h02, 8'hd8 | c[7:0]);
      rd(8'h02, 8'hd0 | c[7:0]);
      check(source_voltage_code, c[7:0]);
    end
    // plain registers through a burst, read-only ones untouched
    i_host.write_regs(8'h03, {8'ha5, 8'h5a}, nak);
    check(nak, 8'h00);
    i_host.read_regs(8'h03, 2, q);
    check(q[0], 8'ha5);
    check(q[1], 8'h5a);
    i_host.write_regs(8'h07, {8'hff, 8'hff}, nak);
    i_host.read_regs(8'h07, 2, q);
    check(q[0], irq_a);
    check(q[1], irq_b);
    wr(8'h0f, 8'h00);
    i_host.read_regs(8'h0f, 3, q);
    check(q[0], rail_good);
    check(q[1], `REVISION_CODE);
    check(q[2], 8'h00);
    // enables alone do nothing in standby, go-active brings all up
    wr(8'h01, 8'h3f);
    repeat (SEQ + 10) @(posedge ref_clk);
    check({device_active, rails}, 8'h00);
    wr(8'h01, 8'hbf);
    wait_active(1'b1);
    check(rails, 8'h3f);
    rd(8'h01, 8'h3f);
    wr(8'h01, 8'h3e);
    check(rails, 8'h3a);
    wr(8'h01, 8'h3b);
    check(rails, 8'h3b);
    wr(8'h01, 8'h3f);
    check(rails, 8'h3f);
    // go-standby, then both requests together
    wr(8'h01, 8'h7f);
    wait_active(1'b0);
    check(rails, 8'h00);
    rd(8'h01, 8'h3f);
    wr(8'h01, 8'hff);
    repeat (SEQ + 10) @(posedge ref_clk);
    check(device_active, 8'h00);
    rd(8'h01, 8'h3f);
    wr(8'h01, 8'hbf);
    wait_active(1'b1);
    wr(8'h01, 8'hff);
    wait_active(1'b0);
    // sleep: defaults restored and bus traffic ignored
    wake_input <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(source_voltage_code, 8'h03);
    wr(8'h02, 8'h05);
    check(nak, 8'h01);
    wake_input <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h23);
    close_out();
  end
endmodule  // display_pmic_rail_control_regs_tb_top
